// ===== design/srdc_sysref_delay_calibration.sv
`timescale 1ns/1ps
// Operation
// [RULE1] Enable low: output manual delay setting.
// [RULE2] Enable high: output calibrated delay, ignore manual.
// [RULE3] Calibration starts only on enable rising.
// [RULE4] Software writes configuration before enabling.
// [RULE5] Software enables only when ADC calibration idle.
// [RULE6] Averaging code selects 4/16/64/256 measurements.
// [RULE7] Length code selects 4/16/64/256 cycles, period limits.
// [RULE8] Clock source keeps SYSREF period within limit.
// [RULE9] Calibration ends within 384*19*4^(avg+len+2) cycles.
// [RULE10] Done flag bit 17 set when finished, enabled.
// [RULE11] Delay bits: 16 invert, 15:8 coarse, 7:0 fine.
// [RULE12] Done low during sequence; no restart while high.
module srdc_sysref_delay_calibration #(
  parameter int BOUND_FACTOR = srdc_pkg::BOUND_FACTOR // Long bound scaler.
) (
  input  wire logic        sys_clk,       // 100 MHz device clock.
  input  wire logic        sys_rst,       // Synchronous reset, active high.
  input  wire logic [11:0] reg_addr,      // Register address.
  input  wire logic [23:0] reg_wdata,     // Register write data.
  input  wire logic        reg_write,     // Write strobe, one cycle.
  output logic      [23:0] reg_rdata,     // Read data, one cycle late.
  input  wire logic        sysref,        // SYSREF timing reference.
  input  wire logic [16:0] manual_delay,  // Manual delay setting.
  output logic      [16:0] aperture_delay // Delay word to the clock path.
);

  // -------------------------------------------------------------------------
  // Declarations.
  // -------------------------------------------------------------------------
  logic [7:0]  sysref_cal_enable;      // Enable register.
  logic [7:0]  sysref_cal_config;      // Configuration register.
  logic [7:0]  next_enable;            // Next enable register.
  logic [7:0]  next_config;            // Next configuration register.
  logic        enable_prev;            // Enable bit one cycle ago.
  logic        sysref_prev;            // SYSREF one cycle ago.
  srdc_pkg::srdc_state_type state;     // Sequencer state.
  srdc_pkg::srdc_state_type next_state;
  logic [8:0]  accum_cnt;              // Cycles left in an accumulation.
  logic [8:0]  next_accum_cnt;
  logic [8:0]  avg_cnt;                // Measurements left.
  logic [8:0]  next_avg_cnt;
  logic [16:0] high_sum;               // SYSREF high samples in total.
  logic [16:0] next_high_sum;
  logic [14:0] period_cnt;             // Cycles since last SYSREF edge.
  logic [14:0] next_period_cnt;
  logic [31:0] bound_cnt;              // Cycles since sequence start.
  logic [31:0] next_bound_cnt;
  logic [16:0] computed_delay_value;   // Result word.
  logic [16:0] next_delay;
  logic [16:0] next_aperture;
  logic [23:0] next_rdata;
  logic        cal_complete_flag;      // Sequence finished while enabled.
  logic        en_bit;                 // Current enable bit.
  logic        start;                  // Rising edge of the enable bit.
  logic        sysref_rise;            // SYSREF rising edge.
  logic [1:0]  cal_average_select;     // Averaging code.
  logic [1:0]  accumulation_length_select; // Length code.
  logic [8:0]  accum_len;              // Cycles per accumulation.
  logic [8:0]  avg_len;                // Measurements per calibration.
  logic [14:0] max_period;             // Longest allowed SYSREF period.
  logic [31:0] bound_limit;            // Duration bound in cycles.
  logic [4:0]  shift;                  // Log2 of samples in total.
  logic [32:0] scaled;                 // Sum scaled to a 16-bit fraction.

  // -------------------------------------------------------------------------
  // Decode of the configuration fields.
  // -------------------------------------------------------------------------
  // The four-power tables come from shifts so that each code costs nothing.
  always_comb begin
    en_bit = sysref_cal_enable[srdc_pkg::EN_BIT];
    start = en_bit && !enable_prev; // [RULE3]
    sysref_rise = sysref && !sysref_prev;
    cal_average_select =
      sysref_cal_config[srdc_pkg::AVG_MSB:srdc_pkg::AVG_LSB];
    accumulation_length_select =
      sysref_cal_config[srdc_pkg::LEN_MSB:srdc_pkg::LEN_LSB];
    avg_len = 9'h004 << {cal_average_select, 1'b0}; // [RULE6]
    accum_len = 9'h004 << {accumulation_length_select, 1'b0}; // [RULE7]
    unique case (accumulation_length_select) // [RULE7]
      2'h0: max_period = srdc_pkg::MAX_PERIOD_0;
      2'h1: max_period = srdc_pkg::MAX_PERIOD_1;
      2'h2: max_period = srdc_pkg::MAX_PERIOD_2;
      2'h3: max_period = srdc_pkg::MAX_PERIOD_3;
    endcase
    shift = 5'({cal_average_select, 1'b0})
          + 5'({accumulation_length_select, 1'b0})
          + 5'(2 * srdc_pkg::BOUND_EXP);
    // [RULE9]
    bound_limit = 32'(BOUND_FACTOR) << shift;
    scaled = {16'h0000, high_sum} << srdc_pkg::SCALE_BITS;
    scaled = scaled >> shift;
    cal_complete_flag = (state == srdc_pkg::SRDC_DONE) && en_bit; // [RULE10]
  end

  // -------------------------------------------------------------------------
  // Register file.
  // -------------------------------------------------------------------------
  // Writes to the status address are dropped; it reports state only.
  always_comb begin
    next_enable = sysref_cal_enable;
    next_config = sysref_cal_config;
    next_rdata = 24'h00_0000;
    if (reg_write && reg_addr == srdc_pkg::ADDR_ENABLE) begin
      next_enable = reg_wdata[7:0];
    end
    if (reg_write && reg_addr == srdc_pkg::ADDR_CONFIG) begin
      next_config = reg_wdata[7:0];
    end
    unique case (reg_addr)
      srdc_pkg::ADDR_ENABLE: next_rdata = {16'h0000, sysref_cal_enable};
      srdc_pkg::ADDR_CONFIG: next_rdata = {16'h0000, sysref_cal_config};
      srdc_pkg::ADDR_STATUS: begin
        next_rdata[srdc_pkg::DONE_BIT] = cal_complete_flag; // [RULE10]
        // [RULE11]
        next_rdata[srdc_pkg::DELAY_W-1:0] = computed_delay_value;
      end
      default: next_rdata = 24'h00_0000;
    endcase
  end

  // Registers the control bits and the read data.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sysref_cal_enable <= srdc_pkg::RST_ENABLE;
      sysref_cal_config <= srdc_pkg::RST_CONFIG;
      reg_rdata         <= 24'h00_0000;
    end else begin
      sysref_cal_enable <= next_enable;
      sysref_cal_config <= next_config;
      reg_rdata         <= next_rdata;
    end
  end

  // -------------------------------------------------------------------------
  // Calibration sequencer.
  // -------------------------------------------------------------------------
  // Each measurement waits for a SYSREF edge, then counts how many of the
  // following cycles see SYSREF high. The mean high fraction is the phase
  // estimate. A SYSREF period over the limit or an overrun of the duration
  // bound ends the sequence in the fail state, with the done flag low.
  always_comb begin
    next_state = state;
    next_accum_cnt = accum_cnt;
    next_avg_cnt = avg_cnt;
    next_high_sum = high_sum;
    next_delay = computed_delay_value;
    next_period_cnt = sysref_rise ? 15'h0000 : period_cnt + 15'h0001;
    next_bound_cnt = bound_cnt + 32'h0000_0001;
    if (!en_bit) begin
      next_state = srdc_pkg::SRDC_IDLE; // Disable aborts any sequence.
    end else if (start) begin
      // [RULE12]
      next_state = srdc_pkg::SRDC_SYNC;
      next_avg_cnt = avg_len;
      next_high_sum = 17'h0_0000;
      next_period_cnt = 15'h0000;
      next_bound_cnt = 32'h0000_0000;
    end else begin
      unique case (state)
        srdc_pkg::SRDC_IDLE: begin
          next_state = srdc_pkg::SRDC_IDLE; // [RULE12]
        end
        srdc_pkg::SRDC_SYNC: begin
          if (sysref_rise) begin
            next_state = srdc_pkg::SRDC_ACCUM;
            next_accum_cnt = accum_len;
          end
        end
        srdc_pkg::SRDC_ACCUM: begin
          next_accum_cnt = accum_cnt - 9'h001;
          if (sysref) begin
            next_high_sum = high_sum + 17'h0_0001;
          end
          if (accum_cnt == 9'h001) begin
            next_avg_cnt = avg_cnt - 9'h001;
            next_state = (avg_cnt == 9'h001) ? srdc_pkg::SRDC_DONE
                                             : srdc_pkg::SRDC_SYNC;
          end
        end
        srdc_pkg::SRDC_DONE: begin
          next_delay = scaled[srdc_pkg::DELAY_W-1:0]; // [RULE11]
        end
        srdc_pkg::SRDC_FAIL: begin
          next_state = srdc_pkg::SRDC_FAIL;
        end
        default: next_state = srdc_pkg::SRDC_IDLE;
      endcase
      // Watchdogs apply only while measuring.
      if (state == srdc_pkg::SRDC_SYNC || state == srdc_pkg::SRDC_ACCUM) begin
        if (period_cnt > max_period || bound_cnt >= bound_limit) begin
          next_state = srdc_pkg::SRDC_FAIL; // [RULE9]
        end
      end
    end
    // Result latches on the cycle the sequence completes.
    if (en_bit && !start && state == srdc_pkg::SRDC_ACCUM
        && next_state == srdc_pkg::SRDC_DONE) begin
      next_delay = 17'({16'h0000, next_high_sum} << srdc_pkg::SCALE_BITS
                       >> shift); // [RULE11]
    end
    // [RULE1] [RULE2]
    next_aperture = en_bit ? next_delay : manual_delay;
  end

  // Registers the sequencer.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state                <= srdc_pkg::SRDC_IDLE;
      enable_prev          <= 1'b0;
      sysref_prev          <= 1'b0;
      accum_cnt            <= 9'h000;
      avg_cnt              <= 9'h000;
      high_sum             <= 17'h0_0000;
      period_cnt           <= 15'h0000;
      bound_cnt            <= 32'h0000_0000;
      computed_delay_value <= 17'h0_0000;
      aperture_delay       <= 17'h0_0000;
    end else begin
      state                <= next_state;
      enable_prev          <= en_bit;
      sysref_prev          <= sysref;
      accum_cnt            <= next_accum_cnt;
      avg_cnt              <= next_avg_cnt;
      high_sum             <= next_high_sum;
      period_cnt           <= next_period_cnt;
      bound_cnt            <= next_bound_cnt;
      computed_delay_value <= next_delay;
      aperture_delay       <= next_aperture;
    end
  end

endmodule // srdc_sysref_delay_calibration

// ===== design/srdc_pkg.sv
package srdc_pkg;

  // -------------------------------------------------------------------------
  // Register map and reset values.
  // -------------------------------------------------------------------------
  localparam logic [11:0] ADDR_ENABLE = 12'h02b0; // Calibration enable.
  localparam logic [11:0] ADDR_CONFIG = 12'h02b1; // Averaging and length.
  localparam logic [11:0] ADDR_STATUS = 12'h02b2; // Done flag and delay.
  localparam logic [7:0]  RST_ENABLE  = 8'h00;    // Calibration off.
  localparam logic [7:0]  RST_CONFIG  = 8'h05;    // Both selects at code 1.

  // -------------------------------------------------------------------------
  // Field positions.
  // -------------------------------------------------------------------------
  localparam int EN_BIT     = 0;  // Enable bit in the enable register.
  localparam int AVG_MSB    = 3;  // Averaging select, upper bit.
  localparam int AVG_LSB    = 2;  // Averaging select, lower bit.
  localparam int LEN_MSB    = 1;  // Accumulation length select, upper bit.
  localparam int LEN_LSB    = 0;  // Accumulation length select, lower bit.
  localparam int DONE_BIT   = 17; // Completion flag in the status word.
  localparam int DELAY_W    = 17; // Width of the delay word.
  localparam int STATUS_W   = 24; // Width of the status register.
  localparam int SCALE_BITS = 16; // Fraction bits of the delay result.

  // -------------------------------------------------------------------------
  // Longest SYSREF period per accumulation length code, in clock cycles.
  // -------------------------------------------------------------------------
  localparam logic [14:0] MAX_PERIOD_0 = 15'h0080; // 128 cycles.
  localparam logic [14:0] MAX_PERIOD_1 = 15'h0680; // 1664 cycles.
  localparam logic [14:0] MAX_PERIOD_2 = 15'h1e80; // 7808 cycles.
  localparam logic [14:0] MAX_PERIOD_3 = 15'h7e80; // 32384 cycles.

  // Duration bound factor: the bound is this times four to the power of
  // the averaging code plus the length code plus two.
  localparam int BOUND_FACTOR = 384 * 19;
  localparam int BOUND_EXP    = 2;

  // -------------------------------------------------------------------------
  // Sequencer states, Gray coded along the usual path.
  // -------------------------------------------------------------------------
  typedef enum logic [2:0] {
    SRDC_IDLE  = 3'h0,
    SRDC_SYNC  = 3'h1,
    SRDC_ACCUM = 3'h3,
    SRDC_DONE  = 3'h2,
    SRDC_FAIL  = 3'h6
  } srdc_state_type;

endpackage

// ===== verif/srdc_sysref_src.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Clock source model: a free-running SYSREF pulse train.
// ---------------------------------------------------------------------------
module srdc_sysref_src (
  input  wire logic        sys_clk,  // Device clock.
  input  wire logic [15:0] period,   // Period in clock cycles.
  input  wire logic [15:0] high_len, // High cycles per period.
  output logic             sysref    // Reference to the block.
);
  logic [15:0] phase; // Position inside the period.
  initial phase = 16'h0000;
  // Moves on the falling edge so the block samples a settled level.
  always @(negedge sys_clk) begin
    if (phase + 16'h0001 >= period) begin
      phase <= 16'h0000;
    end else begin
      phase <= phase + 16'h0001;
    end
  end
  // SYSREF runs free; a long period is only used to force a failure.
  assign sysref = (phase < high_len);
endmodule // srdc_sysref_src

// ===== verif/srdc_sysref_delay_calibration_chk.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Port checker for the calibration block.
// ---------------------------------------------------------------------------
module srdc_sysref_delay_calibration_chk #(
  parameter int BOUND_FACTOR = 7296 // Duration bound scaler.
) (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic [11:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic [23:0] reg_rdata,
  input wire logic        sysref,
  input wire logic [16:0] manual_delay,
  input wire logic [16:0] aperture_delay
);
  logic [7:0]  en_r, cfg_r, next_en, next_cfg; // Register shadows.
  logic [31:0] cnt, next_cnt, bound;           // Cycles since enable.
  logic        seen, next_seen;                // Done already seen.
  wire wr_en  = reg_write && reg_addr == srdc_pkg::ADDR_ENABLE;
  wire wr_cfg = reg_write && reg_addr == srdc_pkg::ADDR_CONFIG;
  // Shadows let reads be predicted without peeking inside.
  always_comb begin
    next_en   = wr_en ? reg_wdata[7:0] : en_r;
    next_cfg  = wr_cfg ? reg_wdata[7:0] : cfg_r;
    next_cnt  = en_r[0] ? cnt + 32'h0000_0001 : 32'h0000_0000;
    next_seen = en_r[0] & (seen | reg_rdata[17]);
    bound     = BOUND_FACTOR << (2 * (cfg_r[3:2] + cfg_r[1:0] + 2));
  end
  // Registers only; reset matches the block's own reset values.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      en_r  <= srdc_pkg::RST_ENABLE;
      cfg_r <= srdc_pkg::RST_CONFIG;
      cnt   <= 32'h0000_0000;
      seen  <= 1'b0;
    end else begin
      en_r  <= next_en;
      cfg_r <= next_cfg;
      cnt   <= next_cnt;
      seen  <= next_seen;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  chk_manual_drive: assert property (disable iff (sys_rst)
    !en_r[0] |=> aperture_delay == $past(manual_delay)) else $error("manual");
  chk_enable_read: assert property (disable iff (sys_rst)
    reg_addr == srdc_pkg::ADDR_ENABLE
    |=> reg_rdata == {16'h0000, $past(en_r)})
    else $error("enable read");
  chk_config_read: assert property (disable iff (sys_rst)
    reg_addr == srdc_pkg::ADDR_CONFIG
    |=> reg_rdata == {16'h0000, $past(cfg_r)})
    else $error("config read");
  chk_done_needs_en: assert property (disable iff (sys_rst)
    !en_r[0] && !$past(en_r[0]) |=> !reg_rdata[17]) else $error("done off");
  chk_done_low_start: assert property (disable iff (sys_rst)
    $rose(en_r[0]) |=> !reg_rdata[17] [*3]) else $error("done early");
  chk_bound_kept: assert property (disable iff (sys_rst)
    en_r[0] && !seen && reg_rdata[17] |-> cnt <= bound + 3)
    else $error("slow");
  chk_delay_drive: assert property (disable iff (sys_rst)
    en_r[0] && reg_rdata[17] ##1 en_r[0] |->
    aperture_delay == $past(reg_rdata[16:0])) else $error("delay");
  chk_reset_clear: assert property (
    sys_rst |=> reg_rdata == 24'h00_0000 && aperture_delay == 17'h0_0000)
    else $error("reset");
  cov_done: cover property (disable iff (sys_rst) en_r[0] && reg_rdata[17]);
  cov_start: cover property (disable iff (sys_rst) $rose(en_r[0]));
  cov_stop: cover property (disable iff (sys_rst) $fell(en_r[0]));
endmodule // srdc_sysref_delay_calibration_chk

bind srdc_sysref_delay_calibration srdc_sysref_delay_calibration_chk #(
  .BOUND_FACTOR(BOUND_FACTOR)) i_srdc_sysref_delay_calibration_chk (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_rdata(reg_rdata),
  .sysref(sysref), .manual_delay(manual_delay),
  .aperture_delay(aperture_delay));

// ===== verif/srdc_sysref_delay_calibration_tb.sv
`timescale 1ns/1ps
module srdc_sysref_delay_calibration_tb;
  localparam int BF = 64; // Short bound keeps the run brief.
  typedef struct {
    logic [3:0] cfg; logic [15:0] per; logic [15:0] hi; logic [16:0] dly;
  } srdc_row_type;
  // Together the rows set every averaging and length code at least once.
  srdc_row_type rows [5] = '{'{4'h0, 16'h0002, 16'h0001, 17'h0_8000},
    '{4'h5, 16'h0004, 16'h0001, 17'h0_4000},
    '{4'ha, 16'h0002, 16'h0001, 17'h0_8000},
    '{4'hc, 16'h0004, 16'h0003, 17'h0_c000},
    '{4'h3, 16'h0004, 16'h0001, 17'h0_4000}};
  logic        sys_clk, sys_rst, reg_write, sysref;
  logic [11:0] reg_addr;
  logic [23:0] reg_wdata, reg_rdata;
  logic [16:0] manual_delay, aperture_delay;
  logic [15:0] period, high_len;
  int          num_errors = 0;
  int          checks = 0;
  srdc_sysref_delay_calibration #(.BOUND_FACTOR(BF))
    i_srdc_sysref_delay_calibration (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_rdata(reg_rdata), .sysref(sysref), .manual_delay(manual_delay),
    .aperture_delay(aperture_delay));
  srdc_sysref_src i_srdc_sysref_src (.sys_clk(sys_clk), .period(period),
    .high_len(high_len), .sysref(sysref));
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Bus tasks start and end just after a falling edge. A write lets one
  // more edge pass so that back to back writes never lower and raise the
  // strobe in the same time step.
  task automatic wr(input logic [11:0] a, input logic [23:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge sys_clk);
    reg_write = 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic rd(input logic [11:0] a, output logic [23:0] d);
    reg_addr = a;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
  // Polls the done flag; running out of the bound ends the run.
  task automatic wait_done(input int lim);
    int i;
    i = 0;
    reg_addr = srdc_pkg::ADDR_STATUS;
    while (reg_rdata[17] !== 1'b1 && i < lim) begin
      @(negedge sys_clk);
      i++;
    end
    if (i >= lim) begin
      num_errors++;
      $display("CHECK FAILED at %0t: calibration timed out", $time);
      finish_test();
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    logic [23:0] d;
    int          lim;
    {sys_rst, reg_write, reg_addr, reg_wdata} = {2'b10, 36'h0_0000_0000};
    {manual_delay, period, high_len} = {17'h0_0000, 16'h0002, 16'h0001};
    repeat (3) @(negedge sys_clk);
    sys_rst = 1'b0;
    rd(srdc_pkg::ADDR_ENABLE, d);
    check(d, 24'h00_0000);
    for (int r = 0; r < 5; r++) begin
      manual_delay = 17'h1_2300 + 17'(r);
      wr(srdc_pkg::ADDR_CONFIG, {20'h0_0000, rows[r].cfg});
      rd(srdc_pkg::ADDR_CONFIG, d);
      check(d, {20'h0_0000, rows[r].cfg});
      check(24'(aperture_delay), 24'(manual_delay));
      {period, high_len} = {rows[r].per, rows[r].hi};
      // No converter calibration ever runs here, so enabling is legal.
      wr(srdc_pkg::ADDR_ENABLE, 24'h00_0001);
      rd(srdc_pkg::ADDR_STATUS, d);
      check(24'(d[17]), 24'h00_0000);
      lim = BF << (2 * (int'(rows[r].cfg[3:2]) + rows[r].cfg[1:0] + 2));
      wait_done(lim);
      rd(srdc_pkg::ADDR_STATUS, d);
      check(d, {7'h01, rows[r].dly});
      check(24'(aperture_delay), 24'(rows[r].dly));
      wr(srdc_pkg::ADDR_ENABLE, 24'h00_0000);
      rd(srdc_pkg::ADDR_STATUS, d);
      check(24'(aperture_delay), 24'(manual_delay));
      $display("row %0d finished", r);
    end
    // A second write of one must not restart; manual input stays ignored.
    {period, high_len} = {16'h0002, 16'h0001};
    wr(srdc_pkg::ADDR_CONFIG, 24'h00_0000);
    wr(srdc_pkg::ADDR_ENABLE, 24'h00_0001);
    wait_done(BF * 16);
    manual_delay = 17'h0_0abc;
    wr(srdc_pkg::ADDR_ENABLE, 24'h00_0001);
    rd(srdc_pkg::ADDR_STATUS, d);
    check(d, 24'h02_8000);
    check(24'(aperture_delay), 24'h00_8000);
    wr(srdc_pkg::ADDR_STATUS, 24'h00_0000);
    rd(srdc_pkg::ADDR_STATUS, d);
    check(d, 24'h02_8000);
    wr(12'h02b3, 24'h00_00ff);
    rd(12'h02b3, d);
    check(d, 24'h00_0000);
    $display("restart and access test finished");
    // A period past the limit fails: done stays low, delay is held.
    wr(srdc_pkg::ADDR_ENABLE, 24'h00_0000);
    period = 16'h012c;
    wr(srdc_pkg::ADDR_ENABLE, 24'h00_0001);
    repeat (1500) @(negedge sys_clk);
    rd(srdc_pkg::ADDR_STATUS, d);
    check(24'(d[17]), 24'h00_0000);
    check(24'(aperture_delay), 24'h00_8000);
    $display("failure test finished");
    // Reset in mid-run returns every register to its reset value.
    wr(srdc_pkg::ADDR_CONFIG, 24'h00_000f);
    sys_rst = 1'b1;
    repeat (3) @(negedge sys_clk);
    check(24'(aperture_delay), 24'h00_0000);
    sys_rst = 1'b0;
    rd(srdc_pkg::ADDR_CONFIG, d);
    check(d, 24'h00_0005);
    rd(srdc_pkg::ADDR_STATUS, d);
    check(d, 24'h00_0000);
    $display("reset test finished");
    finish_test();
  end
endmodule // srdc_sysref_delay_calibration_tb
